// ==== hdl/disp_host_defs.svh ====
/*
 Constants of the display host port: strap codes, register offsets, field positions,
 reset values, address limits and timing counts.
 Assumes a 250 MHz clk_sys and a 32-bit APB register bus.
*/
// Functional notes
// - parallel word moves as one byte or two nibbles, high first on upper lines.
// - command-or-data select low marks instruction, high marks display or glyph data.
// - enable-strobed mode captures a write on enable falling edge with read-not-write low.
// - enable-strobed mode drives read data after enable rising edge with read-not-write high.
// - split-strobe mode latches written word on rising edge of write strobe.
// - split-strobe mode presents read data after falling edge of read strobe.
// - serial transfer is two bytes, MSB first: start byte then payload byte.
// - start byte read-not-write bit one means read, zero means write.
// - start byte command-or-data bit zero means instruction, one means data.
// - serial write samples every bit of both bytes on rising serial clock.
// - serial read still samples start byte bits on rising serial clock.
// - serial read: host waits 1 us, device drives bits after falling clock.
// - frame spans strobe low; acted on only when strobe returns high.
// - power-up reset always; external low reset only in parallel modes.
// - character address steps by one, wrapping 27H/40H and 67H/00H.
// - glyph address steps by one, wrapping between 3FH and 00H.
// - in character RAM the address counter is also the cursor position.
// - character RAM accepts only 00H-27H and 40H-67H.
// - unshifted, line one shows 00-13 and line two shows 40-53.
// - left shift moves window up; right shift down, wrapping line two to 67.
// - busy indication always reads zero.
`ifndef DISP_HOST_DEFS_SVH
`define DISP_HOST_DEFS_SVH

// strap codes of mode_strap
`define MODE_ENABLE_STROBED 2'h0
`define MODE_SPLIT_STROBE 2'h1

// register byte offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_SHIFT 8'h08
`define REG_HOST_WORD 8'h0c
`define REG_READ_DATA 8'h10
`define REG_STATUS 8'h14

// field positions
`define CTRL_STEP_UP 0
`define CTRL_GLYPH_SEL 1
`define SHIFT_LEFT 0
`define SHIFT_RIGHT 1
`define HOST_WORD_CD 8
`define HOST_WORD_PENDING 31
`define STATUS_EARLY_CLK 4

// reset values
`define CTRL_RESET 2'h1
`define READ_DATA_RESET 8'h00

// address map of the counter
`define CHAR_L1_LAST 7'h27
`define CHAR_L2_FIRST 7'h40
`define CHAR_L2_LAST 7'h67
`define GLYPH_LAST 6'h3f
`define WINDOW_LAST 6'h27

// serial start byte
`define START_ONES 5'h1f
`define SER_BITS_HEAD 5'h08
`define SER_BITS_FRAME 5'h10

// least wait between serial bytes on a read
`define SER_WAIT_NS 1000
`define CLK_MHZ 250
`define SER_WAIT_CYC ((`SER_WAIT_NS * `CLK_MHZ + 999) / 1000)

// strap capture delay after reset release
`define STRAP_DELAY 2'h3

`endif

// ==== hdl/disp_host_pkg.sv ====
/*
 Types of the display host port.
 Assumes the constants of disp_host_defs.svh.
*/
package disp_host_pkg;

	typedef enum logic [1:0] {
		MODE_ENABLE,
		MODE_SPLIT,
		MODE_SERIAL
	} port_mode_e;

	typedef enum logic [2:0] {
		SER_IDLE,
		SER_HEAD,
		SER_WRITE,
		SER_READ,
		SER_DROP
	} ser_state_e;

	typedef struct packed {
		logic valid;
		logic cd;
		logic [7:0] data;
	} host_word_s;

endpackage : disp_host_pkg

// ==== hdl/display_host_interface_addr_counter.sv ====
/*
 Host side of a 20x2 character display controller: enable-strobed, split-strobe and
 serial host ports, address counter and display window, with an APB register slave.
 Assumes all host pins are asynchronous to clk_sys and that straps stay static.
*/
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "disp_host_defs.svh"

module display_host_interface_addr_counter
	import disp_host_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// straps
	input wire logic [1:0] mode_strap,
	input wire logic nibble_strap,
	input wire logic ext_reset_strap,
	// parallel host port
	input wire logic strobe_e,
	input wire logic rnw,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic cmd_or_data_sel,
	input wire logic ext_rst_n,
	input wire logic [7:0] host_data_bus_i,
	output logic [7:0] host_data_bus_o,
	output logic host_data_bus_oe,
	// serial host port
	input wire logic serial_clk,
	input wire logic serial_frame_n,
	input wire logic serial_data_i,
	output logic serial_data_o,
	output logic serial_data_oe,
	// display side
	output host_word_s host_word,
	output logic [6:0] cursor_pos,
	output logic cursor_shown,
	output logic [6:0] line1_start,
	output logic [6:0] line2_start
);

	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic glyph);
		logic [6:0] n;
		n = a;
		if (glyph) begin
			if (up)
				n = (a[5:0] == `GLYPH_LAST) ? 7'h00 : {1'b0, a[5:0] + 6'h01};
			else
				n = (a[5:0] == 6'h00) ? {1'b0, `GLYPH_LAST} : {1'b0, a[5:0] - 6'h01};
		end else if (up) begin
			if (a == `CHAR_L1_LAST)
				n = `CHAR_L2_FIRST;
			else if (a == `CHAR_L2_LAST)
				n = 7'h00;
			else
				n = a + 7'h01;
		end else begin
			if (a == `CHAR_L2_FIRST)
				n = `CHAR_L1_LAST;
			else if (a == 7'h00)
				n = `CHAR_L2_LAST;
			else
				n = a - 7'h01;
		end
		return n;
	endfunction : step_addr

	function automatic logic char_addr_ok(input logic [6:0] a);
		return (a <= `CHAR_L1_LAST) || (a >= `CHAR_L2_FIRST && a <= `CHAR_L2_LAST);
	endfunction : char_addr_ok

	// two-stage synchronisers plus one stage for edge detection
	logic [20:0] s1_r, s2_r, s3_r;
	wire [20:0] pins = {mode_strap, nibble_strap, ext_reset_strap, strobe_e, rnw, wr_n, rd_n,
		cmd_or_data_sel, ext_rst_n, serial_clk, serial_frame_n, serial_data_i, host_data_bus_i};
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= 21'h000000;
			s2_r <= 21'h000000;
			s3_r <= 21'h000000;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	wire [1:0] mode_s;
	wire nib_s, extr_en_s, e_s, rnw_s, wr_s, rd_s, cds_s, extr_s, sck_s, stb_s, si_s;
	wire [7:0] db_s;
	assign {mode_s, nib_s, extr_en_s, e_s, rnw_s, wr_s, rd_s, cds_s, extr_s, sck_s, stb_s, si_s, db_s} = s2_r;
	wire e_d = s3_r[16];
	wire wr_d = s3_r[14];
	wire rd_d = s3_r[13];
	wire sck_d = s3_r[10];
	wire stb_d = s3_r[9];

	// straps caught once after reset release
	logic [1:0] strap_cnt_r;
	logic straps_ok_r, nibble_r, ext_reset_en_r;
	port_mode_e mode_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strap_cnt_r <= 2'h0;
			straps_ok_r <= 1'b0;
			mode_r <= MODE_ENABLE;
			nibble_r <= 1'b0;
			ext_reset_en_r <= 1'b0;
		end else if (!straps_ok_r) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == `STRAP_DELAY) begin
				straps_ok_r <= 1'b1;
				mode_r <= (mode_s == `MODE_ENABLE_STROBED) ? MODE_ENABLE :
					(mode_s == `MODE_SPLIT_STROBE) ? MODE_SPLIT : MODE_SERIAL;
				nibble_r <= nib_s;
				ext_reset_en_r <= extr_en_s;
			end
		end
	end

	wire is_enable = straps_ok_r && mode_r == MODE_ENABLE;
	wire is_split = straps_ok_r && mode_r == MODE_SPLIT;
	wire is_serial = straps_ok_r && mode_r == MODE_SERIAL;
	wire soft_rst = ext_reset_en_r && !is_serial && straps_ok_r && !extr_s;

	// control state
	logic [1:0] ctrl_r;
	logic [6:0] addr_counter_r;
	logic [5:0] window_r;
	logic [7:0] read_data_r;
	logic pending_r, early_clk_r;
	host_word_s last_word_r;
	wire step_up = ctrl_r[`CTRL_STEP_UP];
	wire glyph_sel = ctrl_r[`CTRL_GLYPH_SEL];
	// instruction read returns busy=0 and the address counter
	wire [7:0] read_src_cmd = {1'b0, addr_counter_r};
	wire [7:0] read_src_data = read_data_r;

	// parallel port
	wire e_rise = e_s && !e_d;
	wire e_fall = !e_s && e_d;
	wire par_wr = (is_enable && e_fall && !rnw_s) || (is_split && wr_s && !wr_d);
	wire par_rd_go = (is_enable && e_rise && rnw_s) || (is_split && !rd_s && rd_d);
	wire par_rd_end = (is_enable && e_fall) || (is_split && rd_s && !rd_d);
	logic half_r, par_drive_r;
	logic [3:0] hi_nib_r;
	logic [7:0] rd_word_r;
	wire par_last = !nibble_r || half_r;
	wire [7:0] par_wdata = nibble_r ? {hi_nib_r, db_s[7:4]} : db_s;
	wire [7:0] rd_pick = cds_s ? read_src_data : read_src_cmd;
	wire [7:0] rd_first = nibble_r ? {rd_pick[7:4], 4'h0} : rd_pick;
	wire [7:0] rd_second = {rd_word_r[3:0], 4'h0};
	wire par_word_done = par_wr && par_last;
	wire par_rd_done = par_rd_end && par_drive_r && par_last;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			half_r <= 1'b0;
			hi_nib_r <= 4'h0;
			rd_word_r <= 8'h00;
			par_drive_r <= 1'b0;
			host_data_bus_o <= 8'h00;
			host_data_bus_oe <= 1'b0;
		end else if (soft_rst) begin
			half_r <= 1'b0;
			par_drive_r <= 1'b0;
			host_data_bus_oe <= 1'b0;
		end else begin
			if (par_wr && nibble_r && !half_r)
				hi_nib_r <= db_s[7:4];
			if (par_wr || (par_rd_end && par_drive_r))
				half_r <= nibble_r && !half_r;
			if (par_rd_go) begin
				par_drive_r <= 1'b1;
				host_data_bus_oe <= 1'b1;
				if (!half_r)
					rd_word_r <= rd_pick;
				host_data_bus_o <= half_r ? rd_second : rd_first;
			end else if (par_rd_end) begin
				par_drive_r <= 1'b0;
				host_data_bus_oe <= 1'b0;
			end
		end
	end

	// serial port
	wire sck_rise = sck_s && !sck_d;
	wire sck_fall = !sck_s && sck_d;
	wire stb_fall = !stb_s && stb_d;
	wire stb_rise = stb_s && !stb_d;
	ser_state_e ser_state_r, ser_state_nxt;
	logic [4:0] bit_cnt_r;
	logic [7:0] ser_sr_r, ser_out_r;
	logic ser_cd_r;
	logic [7:0] wait_cnt_r;
	wire [7:0] head_byte = {ser_sr_r[6:0], si_s};
	wire head_ok = head_byte[7:3] == `START_ONES && !head_byte[0];
	wire head_done = ser_state_r == SER_HEAD && sck_rise && bit_cnt_r == `SER_BITS_HEAD - 5'h01;
	wire frame_full = bit_cnt_r == `SER_BITS_FRAME;
	wire ser_wr_done = is_serial && stb_rise && ser_state_r == SER_WRITE && frame_full;
	wire ser_rd_done = is_serial && stb_rise && ser_state_r == SER_READ && frame_full;
	wire wait_met = wait_cnt_r >= 8'(`SER_WAIT_CYC);
	wire early_hit = ser_state_r == SER_READ && sck_rise && bit_cnt_r == `SER_BITS_HEAD && !wait_met;

	always_comb begin
		ser_state_nxt = ser_state_r;
		case (ser_state_r)
			SER_IDLE: if (stb_fall) ser_state_nxt = SER_HEAD;
			SER_HEAD: if (head_done) ser_state_nxt = !head_ok ? SER_DROP : head_byte[2] ? SER_READ : SER_WRITE;
			SER_WRITE, SER_READ, SER_DROP: ser_state_nxt = ser_state_r;
			default: ser_state_nxt = SER_IDLE;
		endcase
		if (stb_rise || !is_serial)
			ser_state_nxt = SER_IDLE;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ser_state_r <= SER_IDLE;
			bit_cnt_r <= 5'h00;
			ser_sr_r <= 8'h00;
			ser_out_r <= 8'h00;
			ser_cd_r <= 1'b0;
			wait_cnt_r <= 8'h00;
			serial_data_o <= 1'b0;
			serial_data_oe <= 1'b0;
		end else begin
			ser_state_r <= ser_state_nxt;
			if (stb_fall)
				bit_cnt_r <= 5'h00;
			else if (sck_rise && ser_state_r != SER_IDLE && !frame_full) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
				ser_sr_r <= {ser_sr_r[6:0], si_s};
			end
			if (head_done) begin
				ser_cd_r <= head_byte[1];
				ser_out_r <= head_byte[1] ? read_src_data : read_src_cmd;
				wait_cnt_r <= 8'h00;
			end else if (!wait_met)
				wait_cnt_r <= wait_cnt_r + 8'h01;
			if (ser_state_r == SER_READ && sck_fall && !frame_full) begin
				serial_data_o <= ser_out_r[7];
				serial_data_oe <= 1'b1;
				ser_out_r <= {ser_out_r[6:0], 1'b0};
			end
			if (ser_state_nxt == SER_IDLE)
				serial_data_oe <= 1'b0;
		end
	end

	// word delivery and counter stepping
	wire word_done = par_word_done || ser_wr_done;
	wire word_cd = ser_wr_done ? ser_cd_r : cds_s;
	wire [7:0] word_data = ser_wr_done ? ser_sr_r : par_wdata;
	wire ram_access = (word_done && word_cd) || (par_rd_done && cds_s) || (ser_rd_done && ser_cd_r);

	// apb slave
	wire apb_setup = psel && !penable;
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd = psel && penable && !pwrite;
	wire hit_ctrl = paddr == `REG_CTRL;
	wire hit_addr = paddr == `REG_ADDR;
	wire hit_shift = paddr == `REG_SHIFT;
	wire hit_word = paddr == `REG_HOST_WORD;
	wire hit_rdata = paddr == `REG_READ_DATA;
	wire hit_stat = paddr == `REG_STATUS;
	wire mapped = hit_ctrl || hit_addr || hit_shift || hit_word || hit_rdata || hit_stat;
	wire [6:0] addr_wval = pwdata[6:0];
	wire addr_bad = hit_addr && pwrite && !glyph_sel && !char_addr_ok(addr_wval);
	wire load_addr = apb_wr && hit_addr && !addr_bad;
	wire shift_left = apb_wr && hit_shift && pwdata[`SHIFT_LEFT];
	wire shift_right = apb_wr && hit_shift && pwdata[`SHIFT_RIGHT] && !pwdata[`SHIFT_LEFT];
	wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
		hit_addr ? {25'h0, addr_counter_r} :
		hit_shift ? {26'h0, window_r} :
		hit_word ? {pending_r, 22'h0, last_word_r.cd, last_word_r.data} :
		hit_rdata ? {24'h0, read_data_r} :
		hit_stat ? {27'h0, early_clk_r, ext_reset_en_r, nibble_r, mode_r} : 32'h0;
	wire [6:0] glyph_addr = {1'b0, addr_wval[5:0]};

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (apb_setup) begin
				prdata <= pwrite ? 32'h0 : rd_mux;
				pslverr <= !mapped || addr_bad;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `CTRL_RESET;
			addr_counter_r <= 7'h00;
			window_r <= 6'h00;
			read_data_r <= `READ_DATA_RESET;
			pending_r <= 1'b0;
			early_clk_r <= 1'b0;
			last_word_r <= '0;
			host_word <= '0;
		end else if (soft_rst) begin
			ctrl_r <= `CTRL_RESET;
			addr_counter_r <= 7'h00;
			window_r <= 6'h00;
			pending_r <= 1'b0;
			host_word <= '0;
		end else begin
			if (apb_wr && hit_ctrl)
				ctrl_r <= pwdata[1:0];
			if (apb_wr && hit_rdata)
				read_data_r <= pwdata[7:0];
			if (load_addr)
				addr_counter_r <= glyph_sel ? glyph_addr : addr_wval;
			else if (ram_access)
				addr_counter_r <= step_addr(addr_counter_r, step_up, glyph_sel);
			if (shift_left)
				window_r <= (window_r == `WINDOW_LAST) ? 6'h00 : window_r + 6'h01;
			else if (shift_right)
				window_r <= (window_r == 6'h00) ? `WINDOW_LAST : window_r - 6'h01;
			host_word <= '{valid: word_done, cd: word_cd, data: word_data};
			if (word_done) begin
				last_word_r <= '{valid: 1'b1, cd: word_cd, data: word_data};
				pending_r <= 1'b1;
			end else if (apb_rd && hit_word)
				pending_r <= 1'b0;
			if (early_hit)
				early_clk_r <= 1'b1;
			else if (apb_wr && hit_stat && pwdata[`STATUS_EARLY_CLK])
				early_clk_r <= 1'b0;
		end
	end

	// display side view
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cursor_pos <= 7'h00;
			cursor_shown <= 1'b0;
			line1_start <= 7'h00;
			line2_start <= `CHAR_L2_FIRST;
		end else begin
			cursor_pos <= addr_counter_r;
			cursor_shown <= !glyph_sel && char_addr_ok(addr_counter_r);
			line1_start <= {1'b0, window_r};
			line2_start <= `CHAR_L2_FIRST | {1'b0, window_r};
		end
	end

endmodule : display_host_interface_addr_counter

// ==== sim/disp_host_monitor.sv ====
/*
 Checker of the display host port, bound to its top module.
 Assumes straps only change while rst_b is low.
*/
`timescale 1ns/1ns

module disp_host_monitor
	import disp_host_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// straps and host pins
	input wire logic [1:0] mode_strap,
	input wire logic nibble_strap,
	input wire logic strobe_e,
	input wire logic rnw,
	input wire logic rd_n,
	input wire logic serial_frame_n,
	// outputs
	input wire logic host_data_bus_oe,
	input wire logic serial_data_oe,
	input wire host_word_s host_word,
	input wire logic [6:0] cursor_pos,
	input wire logic cursor_shown,
	input wire logic [6:0] line1_start,
	input wire logic [6:0] line2_start
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	chk_en_capture: assert property (
		mode_strap == 2'h0 && !nibble_strap && !rnw && $fell(strobe_e) |-> ##[1:6] host_word.valid)
		else $error("enable write not taken");
	chk_en_drive: assert property (
		mode_strap == 2'h0 && rnw && $rose(strobe_e) |-> ##[1:6] host_data_bus_oe)
		else $error("enable read not driven");
	chk_split_drive: assert property (
		mode_strap == 2'h1 && $fell(rd_n) |-> ##[1:6] host_data_bus_oe)
		else $error("split read not driven");
	chk_word_pulse: assert property (host_word.valid |=> !host_word.valid)
		else $error("word pulse too long");
	chk_cursor_range: assert property (cursor_shown |-> cursor_pos <= 7'h27 ||
		(cursor_pos >= 7'h40 && cursor_pos <= 7'h67)) else $error("cursor outside char ram");
	chk_window_pair: assert property (
		line2_start == line1_start + 7'h40 && line1_start <= 7'h27) else $error("window lines apart");
	chk_serial_release: assert property (serial_frame_n [*8] |-> !serial_data_oe)
		else $error("serial line held after frame");
	chk_serial_quiet: assert property (mode_strap[1] |-> !host_data_bus_oe)
		else $error("parallel bus driven in serial mode");

	cover property (host_word.valid && host_word.cd);
	cover property (serial_data_oe);
	cover property (!cursor_shown);
endmodule : disp_host_monitor

bind display_host_interface_addr_counter disp_host_monitor i_disp_host_monitor (
	.clk_sys(clk_sys), .rst_b(rst_b), .mode_strap(mode_strap), .nibble_strap(nibble_strap),
	.strobe_e(strobe_e), .rnw(rnw), .rd_n(rd_n), .serial_frame_n(serial_frame_n),
	.host_data_bus_oe(host_data_bus_oe), .serial_data_oe(serial_data_oe), .host_word(host_word),
	.cursor_pos(cursor_pos), .cursor_shown(cursor_shown), .line1_start(line1_start),
	.line2_start(line2_start));

// ==== sim/host_port_model.sv ====
/*
 Host model: drives parallel strobes and serial frames at pin level.
 Assumes the bench resolves the shared data lines with pull-ups.
*/
`timescale 1ns/1ns

module host_port_model (
	// clock and straps
	input wire logic clk_sys,
	input wire logic [1:0] mode,
	input wire logic nib,
	// parallel pins
	output logic strobe_e,
	output logic rnw,
	output logic wr_n,
	output logic rd_n,
	output logic cd_sel,
	output logic drv,
	output logic [7:0] dq,
	input wire logic [7:0] bus,
	// serial pins
	output logic sck,
	output logic frame_n,
	output logic si_oe,
	output logic si,
	input wire logic sdo
);
	initial begin
		{strobe_e, rnw, cd_sel, drv, si_oe} = 5'h00;
		{wr_n, rd_n, sck, frame_n, si} = 5'h1f;
		dq = 8'h00;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt

	task automatic par_xfer(input logic rd, input logic c, input logic [7:0] d, output logic [7:0] q);
		q = 8'h00;
		for (int i = 0; i < (nib ? 2 : 1); i++) begin
			@(posedge clk_sys);
			cd_sel <= c;
			rnw <= rd;
			drv <= !rd;
			dq <= !nib ? d : (i == 0 ? {d[7:4], 4'h5} : {d[3:0], 4'ha});
			wt(6);
			strobe_e <= mode == 2'h0;
			wr_n <= !(mode == 2'h1 && !rd);
			rd_n <= !(mode == 2'h1 && rd);
			wt(60);
			q = nib ? {q[3:0], bus[7:4]} : bus;
			strobe_e <= 1'b0;
			wr_n <= 1'b1;
			rd_n <= 1'b1;
			wt(60);
		end
		drv <= 1'b0;
	endtask : par_xfer

	// link clock idles high and only runs inside a frame
	task automatic ser_frame(input logic rd, input logic c, input logic [7:0] d, input int nb,
		output logic [7:0] q);
		logic [15:0] w;
		w = {5'h1f, rd, c, 1'b0, d};
		q = 8'h00;
		@(posedge clk_sys);
		frame_n <= 1'b0;
		si_oe <= 1'b1;
		wt(30);
		for (int i = 0; i < nb; i++) begin
			#63 sck = 1'b0;
			si = w[15 - i];
			si_oe = !(rd && i >= 8);
			#62 q = {q[6:0], sdo};
			sck = 1'b1;
			if (rd && i == 7)
				#1100;
		end
		#63;
		@(posedge clk_sys);
		frame_n <= 1'b1;
		si_oe <= 1'b0;
		wt(150);
	endtask : ser_frame
endmodule : host_port_model

// ==== sim/display_host_interface_addr_counter_tb.sv ====
/*
 Testbench of the display host port: apb tasks, host model, checker.
 Assumes host_port_model and disp_host_monitor are compiled first.
*/
`timescale 1ns/1ns

module display_host_interface_addr_counter_tb import disp_host_pkg::*; ;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q32;
	logic pready, pslverr, nibble_strap = 1'b0, ext_rst_n = 1'b1, ext_strap = 1'b1;
	logic [1:0] mode_strap = 2'h0;
	logic strobe_e, rnw, wr_n, rd_n, cd_sel, drv, sck, frame_n, si_oe, si, bus_oe, so, so_oe, shown;
	logic [7:0] dq, bus_o, q8;
	logic [6:0] cursor_pos, line1_start, line2_start;
	host_word_s host_word, last_w;
	int n_mismatch = 0, n_tests = 0, n_words = 0, cyc = 0;
	logic [23:0] wrap [6] = '{24'h012740, 24'h016700, 24'h004027, 24'h000067, 24'h033f00, 24'h02003f};
	wire logic [7:0] bus_w = bus_oe ? bus_o : (drv ? dq : 8'hff);
	wire logic sdi = so_oe ? so : (si_oe ? si : 1'b1);

	display_host_interface_addr_counter i_display_host_interface_addr_counter (
		.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mode_strap(mode_strap), .nibble_strap(nibble_strap), .ext_reset_strap(ext_strap),
		.strobe_e(strobe_e), .rnw(rnw), .wr_n(wr_n), .rd_n(rd_n), .cmd_or_data_sel(cd_sel),
		.ext_rst_n(ext_rst_n), .host_data_bus_i(bus_w), .host_data_bus_o(bus_o),
		.host_data_bus_oe(bus_oe), .serial_clk(sck), .serial_frame_n(frame_n),
		.serial_data_i(sdi), .serial_data_o(so), .serial_data_oe(so_oe), .host_word(host_word),
		.cursor_pos(cursor_pos), .cursor_shown(shown), .line1_start(line1_start),
		.line2_start(line2_start));

	host_port_model i_host_port_model (
		.clk_sys(clk_sys), .mode(mode_strap), .nib(nibble_strap), .strobe_e(strobe_e), .rnw(rnw),
		.wr_n(wr_n), .rd_n(rd_n), .cd_sel(cd_sel), .drv(drv), .dq(dq), .bus(bus_w), .sck(sck),
		.frame_n(frame_n), .si_oe(si_oe), .si(si), .sdo(sdi));

	always #2 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		if (host_word.valid === 1'b1) begin
			last_w <= host_word;
			n_words <= n_words + 1;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : apb

	task automatic boot(input logic [1:0] m, input logic nb);
		rst_b <= 1'b0;
		mode_strap <= m;
		nibble_strap <= nb;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (12) @(posedge clk_sys);
	endtask : boot

	task automatic put(input logic c, input logic [7:0] d, input logic [6:0] pos);
		if (mode_strap[1])
			i_host_port_model.ser_frame(1'b0, c, d, 16, q8);
		else
			i_host_port_model.par_xfer(1'b0, c, d, q8);
		chk("word", {1'b1, c, d}, last_w);
		chk("cursor", pos, cursor_pos);
	endtask : put

	task automatic get(input logic c, input logic [7:0] exp);
		if (mode_strap[1])
			i_host_port_model.ser_frame(1'b1, c, 8'h00, 16, q8);
		else
			i_host_port_model.par_xfer(1'b1, c, 8'h00, q8);
		chk("read", exp, q8);
	endtask : get

	task automatic ext_pulse();
		ext_rst_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		ext_rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask : ext_pulse

	initial begin
		boot(2'h0, 1'b0);
		chk("line1", 7'h00, line1_start);
		chk("line2", 7'h40, line2_start);
		apb(1'b0, 8'h00, 0, q32);
		chk("ctrl", 32'h1, q32);
		apb(1'b0, 8'h14, 0, q32);
		chk("status", 32'h8, q32);
		apb(1'b0, 8'h40, 0, q32);
		chk("slverr", 1'b1, err);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, 8'h00, 32'(wrap[i][23:16]), q32);
			apb(1'b1, 8'h04, 32'(wrap[i][15:8]), q32);
			put(1'b1, 8'(i) + 8'h30, wrap[i][6:0]);
			chk("shown", !wrap[i][17], shown);
		end
		put(1'b0, 8'h01, 7'h3f);
		apb(1'b1, 8'h00, 1, q32);
		chk("shown", 1'b0, shown);
		apb(1'b1, 8'h04, 5, q32);
		apb(1'b1, 8'h10, 32'ha3, q32);
		get(1'b1, 8'ha3);
		get(1'b0, 8'h06);
		apb(1'b1, 8'h08, 1, q32);
		chk("line2", 7'h41, line2_start);
		apb(1'b1, 8'h08, 2, q32);
		apb(1'b1, 8'h08, 2, q32);
		chk("line1", 7'h27, line1_start);
		chk("line2", 7'h67, line2_start);
		ext_pulse();
		chk("ext reset", 7'h00, cursor_pos);
		ext_strap <= 1'b0;
		boot(2'h1, 1'b1);
		apb(1'b0, 8'h14, 0, q32);
		chk("status", 32'h5, q32);
		put(1'b1, 8'hc5, 7'h01);
		apb(1'b1, 8'h10, 32'h5a, q32);
		get(1'b1, 8'h5a);
		ext_pulse();
		chk("ext reset off", 7'h02, cursor_pos);
		ext_strap <= 1'b1;
		boot(2'h2, 1'b0);
		put(1'b0, 8'h3c, 7'h00);
		put(1'b1, 8'h81, 7'h01);
		apb(1'b1, 8'h10, 32'h96, q32);
		get(1'b1, 8'h96);
		q32 = 32'(n_words);
		i_host_port_model.ser_frame(1'b0, 1'b1, 8'h55, 8, q8);
		chk("cut frame", q32, 32'(n_words));
		ext_pulse();
		chk("serial cursor", 7'h02, cursor_pos);
		end_sim();
	end
endmodule : display_host_interface_addr_counter_tb
